// File: design/lecea_pkg.sv
// Purpose: Shared constants and types for the line cycle energy accumulator
// Assumes: Single 40 MHz clock domain
// Notes:   Bit positions refer to the 8-bit mode and gain register ports
package lecea_pkg;
    localparam int unsigned SAMPLE_W       = 24;
    localparam int unsigned ENERGY_W       = 32;
    localparam int unsigned LPF_SHIFT      = 6;
    localparam int unsigned CYC_W          = 16;
    // Measurement mode: zero-crossing count enables, phases A..C
    localparam int unsigned MM_ZC_LSB      = 4;
    // Power mode: formula field and term selects
    localparam int unsigned PM_FORM_LSB    = 6;
    localparam int unsigned PM_TERM_LSB    = 3;
    localparam int unsigned WM_REACT_BIT   = 5;
    localparam int unsigned GAIN_ABS_BIT   = 2;
    // Line energy LSB is a quarter of the active energy LSB
    localparam int unsigned LINE_LSB_SHIFT = 2;
    // Reactive scale: 65536 / 9.546
    localparam logic [15:0] REACT_SCALE    = 16'h1AD1;
    localparam int unsigned REACT_SHIFT    = 16;
    localparam logic [15:0] CYC_RESET      = 16'h0000;

    typedef enum logic [1:0] {
        LECEA_FORM_WYE   = 2'h0,
        LECEA_FORM_DELTA = 2'h1,
        LECEA_FORM_MIXED = 2'h2
    } lecea_formula_e;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] a;
        logic signed [SAMPLE_W-1:0] b;
        logic signed [SAMPLE_W-1:0] c;
    } lecea_phase3_s;

    typedef struct packed {
        logic [1:0] formula;
        logic [2:0] term_en;
        logic [2:0] zc_sel;
        logic       reactive;
        logic       abs_sum;
    } lecea_cfg_s;

    function automatic lecea_cfg_s lecea_decode(
        input logic [7:0] mm,
        input logic [7:0] pm,
        input logic [7:0] wm,
        input logic [7:0] gn
    );
        lecea_cfg_s c;
        c.formula  = pm[PM_FORM_LSB +: 2];
        c.term_en  = pm[PM_TERM_LSB +: 3];
        c.zc_sel   = mm[MM_ZC_LSB +: 3];
        c.reactive = wm[WM_REACT_BIT];
        c.abs_sum  = gn[GAIN_ABS_BIT];
        return c;
    endfunction
endpackage

// File: design/lecea_power_lpf.sv
// Purpose: One power term: voltage times current, then low-pass to DC
// Assumes: Samples arrive with a one-cycle valid strobe
// Notes:   First-order IIR, corner set by SHIFT
`timescale 1ns/1ps
`default_nettype none
module lecea_power_lpf #(
    parameter int unsigned VW    = 24,
    parameter int unsigned IW    = 25,
    parameter int unsigned OW    = 24,
    parameter int unsigned SHIFT = 6
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 valid_i,
    input  wire logic signed [VW-1:0] volt_i,
    input  wire logic signed [IW-1:0] curr_i,
    output logic signed [OW-1:0]      power_o
);
    logic signed [VW+IW-1:0] prod;
    logic signed [OW-1:0]    inst;
    logic signed [OW:0]      diff;

    assign prod = volt_i * curr_i;
    // Drop the redundant sign bit of the product
    assign inst = prod[VW+IW-2 -: OW];
    assign diff = {inst[OW-1], inst} - {power_o[OW-1], power_o};

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_o <= '0;
        end else if (valid_i) begin
            power_o <= power_o + OW'(diff >>> SHIFT);
        end
    end
endmodule // lecea_power_lpf
`default_nettype wire

// File: design/lecea_half_cycle_ctr.sv
// Purpose: Counts selected zero crossings up to the programmed total
// Assumes: Zero-crossing pulses come from logic on the same clock
// Notes:   Coincident crossings on several phases count once
`timescale 1ns/1ps
`default_nettype none
module lecea_half_cycle_ctr #(
    parameter int unsigned CW = 16
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rst_i,
    input  wire logic [2:0]    zc_i,
    input  wire logic [2:0]    zc_sel_i,
    input  wire logic [CW-1:0] target_i,
    output logic               done_o,
    output logic [CW-1:0]      count_o
);
    logic          hit;
    logic [CW-1:0] next_count;

    assign hit        = |(zc_i & zc_sel_i);
    assign next_count = count_o + CW'(1);
    // Zero target never completes
    assign done_o = hit && (target_i != '0) && (next_count >= target_i);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= CW'(lecea_pkg::CYC_RESET);
        end else if (done_o) begin
            count_o <= '0;
        end else if (hit) begin
            count_o <= next_count;
        end
    end

    AST_CNT_BOUND: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (target_i != '0 && $stable(target_i)) |-> count_o < target_i)
        else $error("Half-cycle count reached target without completing");
endmodule // lecea_half_cycle_ctr
`default_nettype wire

// File: design/lecea_line_accum.sv
// Purpose: Line energy accumulation over whole half line cycles
// Assumes: Samples already gain corrected and high-pass filtered
// Notes:   Apparent power path not included
`timescale 1ns/1ps
`default_nettype none
module lecea_line_accum #(
    parameter int unsigned SW = lecea_pkg::SAMPLE_W,
    parameter int unsigned EW = lecea_pkg::ENERGY_W
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     sample_valid_i,
    input  wire lecea_pkg::lecea_phase3_s volt_i,
    input  wire lecea_pkg::lecea_phase3_s curr_i,
    input  wire lecea_pkg::lecea_phase3_s curr_shift_i,
    input  wire logic [2:0]               zc_pulse_i,
    input  wire logic [7:0]               measurement_mode_reg_i,
    input  wire logic [7:0]               power_mode_reg_i,
    input  wire logic [7:0]               waveform_mode_reg_i,
    input  wire logic [7:0]               gain_reg_i,
    input  wire logic [15:0]              half_cycle_count_i,
    input  wire logic                     eoc_mask_i,
    input  wire logic                     eoc_clear_i,
    output logic [2:0]                    zc_enable_o,
    output logic [EW-1:0]                 line_active_energy_acc_o,
    output logic [EW-1:0]                 line_apparent_energy_acc_o,
    output logic                          eoc_flag_o,
    output logic                          period_done_o,
    output logic                          irq_n_o,
    output logic                          irq_n_oe_o
);
    localparam int unsigned IW = SW + 1;
    localparam int unsigned PW = SW + 4;

    lecea_pkg::lecea_cfg_s cfg;
    logic signed [SW-1:0]  term_v [3];
    logic signed [IW-1:0]  term_i [3];
    logic signed [IW-1:0]  term_q [3];
    logic signed [SW-1:0]  act_p  [3];
    logic signed [SW-1:0]  rea_p  [3];
    logic [2:0]            term_on;
    logic                  valid_q;
    logic signed [PW-1:0]  act_sum;
    logic signed [PW-1:0]  mag_sum;
    logic signed [PW-1:0]  rea_sum;
    logic signed [PW+16:0] rea_scaled;
    logic signed [EW-1:0]  la_add;
    logic signed [EW-1:0]  lva_add;
    logic signed [EW-1:0]  la_run;
    logic signed [EW-1:0]  lva_run;
    logic [15:0]           cyc_count;

    ////////////////////////////////////////////////////////////////////////
    // Configuration decode

    assign cfg         = lecea_pkg::lecea_decode(measurement_mode_reg_i, power_mode_reg_i,
                                                 waveform_mode_reg_i, gain_reg_i);
    assign zc_enable_o = cfg.zc_sel;

    function automatic logic signed [IW-1:0] ext(input logic signed [SW-1:0] x);
        return IW'(x);
    endfunction

    // One extra bit so the most negative sample still turns positive
    function automatic logic signed [SW:0] mag(input logic signed [SW-1:0] x);
        logic signed [SW:0] w;
        w = (SW+1)'(x);
        return w[SW] ? -w : w;
    endfunction

    // Formula picks the current feeding each term; middle term idles in 1, 2
    function automatic logic signed [IW-1:0] pick_curr(
        input logic [1:0]              form,
        input int                      k,
        input lecea_pkg::lecea_phase3_s c
    );
        logic signed [IW-1:0] r;
        r = '0;
        unique case (form)
            lecea_pkg::LECEA_FORM_WYE: begin
                r = (k == 0) ? ext(c.a) : (k == 1) ? ext(c.b) : ext(c.c);
            end
            lecea_pkg::LECEA_FORM_DELTA: begin
                r = (k == 0) ? ext(c.a) - ext(c.b) : (k == 1) ? '0 : ext(c.c) - ext(c.b);
            end
            lecea_pkg::LECEA_FORM_MIXED: begin
                r = (k == 0) ? ext(c.a) - ext(c.b) : (k == 1) ? '0 : ext(c.c);
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-term active and reactive power

    assign term_v[0] = volt_i.a;
    assign term_v[1] = volt_i.b;
    assign term_v[2] = volt_i.c;

    generate
        for (genvar k = 0; k < 3; k++) begin : g_term
            assign term_i[k]  = pick_curr(cfg.formula, k, curr_i);
            assign term_q[k]  = pick_curr(cfg.formula, k, curr_shift_i);
            assign term_on[k] = cfg.term_en[k];

            lecea_power_lpf #(
                .VW    (SW),
                .IW    (IW),
                .OW    (SW),
                .SHIFT (lecea_pkg::LPF_SHIFT)
            ) u_act (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .valid_i   (sample_valid_i),
                .volt_i    (term_v[k]),
                .curr_i    (term_i[k]),
                .power_o   (act_p[k])
            );

            // Shifted current gives the reactive product
            lecea_power_lpf #(
                .VW    (SW),
                .IW    (IW),
                .OW    (SW),
                .SHIFT (lecea_pkg::LPF_SHIFT)
            ) u_rea (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .valid_i   (sample_valid_i),
                .volt_i    (term_v[k]),
                .curr_i    (term_q[k]),
                .power_o   (rea_p[k])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Term summation

    always_comb begin
        act_sum = '0;
        mag_sum = '0;
        rea_sum = '0;
        for (int k = 0; k < 3; k++) begin
            if (term_on[k]) begin
                act_sum = act_sum + PW'(act_p[k]);
                mag_sum = mag_sum + PW'(mag(act_p[k]));
                rea_sum = rea_sum + PW'(rea_p[k]);
            end
        end
    end

    // Shifted-current product is scaled down so full-scale ratio holds
    assign rea_scaled = (PW+17)'(rea_sum) * $signed({1'b0, lecea_pkg::REACT_SCALE});

    always_comb begin
        if (cfg.reactive) begin
            la_add  = EW'(rea_scaled >>> lecea_pkg::REACT_SHIFT) <<< lecea_pkg::LINE_LSB_SHIFT;
            lva_add = EW'(mag_sum) <<< lecea_pkg::LINE_LSB_SHIFT;
        end else begin
            la_add  = EW'(cfg.abs_sum ? mag_sum : act_sum) <<< lecea_pkg::LINE_LSB_SHIFT;
            // Apparent accumulation lives outside this block
            lva_add = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Half-cycle counting

    lecea_half_cycle_ctr #(
        .CW (lecea_pkg::CYC_W)
    ) u_ctr (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .zc_i      (zc_pulse_i),
        .zc_sel_i  (cfg.zc_sel),
        .target_i  (half_cycle_count_i),
        .done_o    (period_done_o),
        .count_o   (cyc_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Accumulators

    // Filter outputs settle one cycle after the strobe
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= sample_valid_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            la_run  <= '0;
            lva_run <= '0;
        end else if (period_done_o) begin
            // A sample landing on the boundary opens the next period
            la_run  <= valid_q ? la_add : '0;
            lva_run <= valid_q ? lva_add : '0;
        end else if (valid_q) begin
            la_run  <= la_run + la_add;
            lva_run <= lva_run + lva_add;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_active_energy_acc_o   <= '0;
            line_apparent_energy_acc_o <= '0;
        end else if (period_done_o) begin
            line_active_energy_acc_o   <= la_run;
            line_apparent_energy_acc_o <= lva_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flag and interrupt

    // Set wins over a coincident clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            eoc_flag_o <= 1'b0;
        end else if (period_done_o) begin
            eoc_flag_o <= 1'b1;
        end else if (eoc_clear_i) begin
            eoc_flag_o <= 1'b0;
        end
    end

    // Open drain: only ever pulls low
    assign irq_n_o    = 1'b0;
    assign irq_n_oe_o = eoc_flag_o & eoc_mask_i;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_done;
        period_done_o;
    endsequence

    sequence s_flag_up;
        eoc_flag_o ##1 (eoc_flag_o || $past(eoc_clear_i));
    endsequence

    AST_ZC_ENABLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        zc_enable_o == measurement_mode_reg_i[lecea_pkg::MM_ZC_LSB +: 3])
        else $error("Zero-crossing enables differ from mode bits");

    AST_FLAG_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_done |=> s_flag_up)
        else $error("End-of-cycle flag not set after period end");

    AST_IRQ_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (eoc_flag_o && eoc_mask_i) |-> (irq_n_oe_o && !irq_n_o))
        else $error("Interrupt not asserted with flag and mask set");

    AST_IRQ_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !eoc_mask_i |-> !irq_n_oe_o)
        else $error("Interrupt driven while masked");

    AST_PUBLISH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_done |=> line_active_energy_acc_o == $past(la_run))
        else $error("Line active result not published at period end");

    AST_RESTART: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_done ##0 !valid_q) |=> (la_run == '0 && lva_run == '0))
        else $error("Accumulation did not restart");

    AST_ACC_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (valid_q && !period_done_o) |=> la_run == $past(la_run) + $past(la_add))
        else $error("Line active accumulator missed a sample");

    AST_LVA_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!cfg.reactive && !period_done_o) |=> lva_run == $past(lva_run))
        else $error("Line apparent accumulator moved in normal mode");

    AST_LVA_POS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cfg.reactive |-> !lva_add[EW-1])
        else $error("Negative addend to unsigned accumulator");

    AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !period_done_o |=> $stable(line_active_energy_acc_o))
        else $error("Published result changed mid-period");

    AST_HOLD_LVA: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !period_done_o |=> $stable(line_apparent_energy_acc_o))
        else $error("Published apparent result changed mid-period");

    AST_PUBLISH_LVA: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_done |=> line_apparent_energy_acc_o == $past(lva_run))
        else $error("Line apparent result not published at period end");

    AST_LVA_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (valid_q && !period_done_o) |=> lva_run == $past(lva_run) + $past(lva_add))
        else $error("Line apparent accumulator missed a sample");

    AST_FLAG_CLEAR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (eoc_clear_i && !period_done_o) |=> !eoc_flag_o)
        else $error("End-of-cycle flag survived a clear");

    AST_FLAG_STICKY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!eoc_clear_i && !period_done_o) |=> $stable(eoc_flag_o))
        else $error("End-of-cycle flag moved without cause");

    AST_LSB_QUARTER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (la_add[1:0] == 2'h0) && (lva_add[1:0] == 2'h0))
        else $error("Line addend not on the quarter LSB grid");

    AST_TERMS_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (term_on == 3'h0) |-> (la_add == '0 && lva_add == '0))
        else $error("Disabled terms still reach the accumulators");

    AST_MIDDLE_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cfg.formula != lecea_pkg::LECEA_FORM_WYE) |-> (term_i[1] == '0 && term_q[1] == '0))
        else $error("Middle term carries current outside the wye formula");

    AST_ABS_SUM: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!cfg.reactive && cfg.abs_sum) |-> !la_add[EW-1])
        else $error("Magnitude sum gave a negative addend");
endmodule // lecea_line_accum
`default_nettype wire

// File: tb/lecea_host_model.sv
// Purpose: Host side model that services the end-of-cycle flag
// Assumes: Host polls the status flag on the chip clock
// Notes:   Clears a few cycles late, so the bench sees the flag stand
`timescale 1ns/1ps
`default_nettype none
module lecea_host_model #(
    parameter int unsigned LAT = 3
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic eoc_flag_i,
    output logic      eoc_clear_o
);
    int unsigned wait_cnt;

    ////////////////////////////////////////////////////////////////
    // One clear pulse per flag, raised once wait_cnt reaches LAT
    always @(negedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt    <= 0;
            eoc_clear_o <= 1'b0;
        end else begin
            eoc_clear_o <= eoc_flag_i && (wait_cnt == LAT);
            wait_cnt    <= eoc_flag_i ? wait_cnt + 1 : 0;
        end
    end
endmodule // lecea_host_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the line cycle energy accumulator
// Assumes: Inputs driven at the falling edge, outputs read 2.5 ns before rise
// Notes:   Energies are judged by sign class; filter values are not modelled
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [1:0] la;
        logic [1:0] lva;
        logic       mask;
    } lecea_note_s;

    logic                    ref_clk_i = 1'b0;
    logic                    rst_i;
    logic                    sample_valid_i;
    lecea_pkg::lecea_phase3_s volt, curr, cshift;
    logic [2:0]              zc_pulse_i, zc_enable_o;
    logic [7:0]              mm, pm, wm, gn;
    logic [15:0]             cyc;
    logic                    eoc_mask_i, eoc_clear_i, eoc_flag_o, period_done_o, irq_n_o, irq_n_oe_o;
    logic [31:0]             la_o, lva_o, rs;
    lecea_note_s             notes[$];
    lecea_note_s             n;
    logic                    pend = 1'b0;
    logic                    hung = 1'b0;
    int                      err_count = 0;
    int                      check_count = 0;
    int                      scn = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    lecea_line_accum dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sample_valid_i(sample_valid_i),
        .volt_i(volt), .curr_i(curr), .curr_shift_i(cshift), .zc_pulse_i(zc_pulse_i),
        .measurement_mode_reg_i(mm), .power_mode_reg_i(pm), .waveform_mode_reg_i(wm),
        .gain_reg_i(gn), .half_cycle_count_i(cyc), .eoc_mask_i(eoc_mask_i),
        .eoc_clear_i(eoc_clear_i), .zc_enable_o(zc_enable_o), .line_active_energy_acc_o(la_o),
        .line_apparent_energy_acc_o(lva_o), .eoc_flag_o(eoc_flag_o),
        .period_done_o(period_done_o), .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o)
    );

    lecea_host_model host (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .eoc_flag_i(eoc_flag_o), .eoc_clear_o(eoc_clear_i)
    );

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // 0 zero, 1 positive, 2 negative, 3 unknown
    function automatic logic [1:0] cls(input logic [31:0] e, input logic sgn);
        if ($isunknown(e)) return 2'h3;
        if (e === 32'h0) return 2'h0;
        return (sgn && e[31]) ? 2'h2 : 2'h1;
    endfunction

    task automatic chk_energy(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_stat(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Result watcher: one note per period end, judged one cycle later
    always @(negedge ref_clk_i) begin
        #10;
        if (pend) begin
            pend = 1'b0;
            n = notes.pop_front();
            chk_energy(cls(la_o, 1'b1), n.la);
            chk_energy(cls(lva_o, 1'b0), n.lva);
            chk_stat({2'h0, la_o[1:0]}, 4'h0);
            chk_stat({1'b0, eoc_flag_o, irq_n_oe_o, irq_n_o}, {2'h1, n.mask, 1'b0});
        end
        if (period_done_o === 1'b1) begin
            if (notes.size() == 0) chk_stat(4'hF, 4'h0);
            else pend = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic run(input logic [1:0] form, input logic [2:0] term, input logic rx, ab, ineg, sneg,
                       input logic [1:0] ela, input logic [1:0] elva);
        logic [31:0] r;
        logic [2:0]  sel;
        logic [23:0] m;
        if (hung) return;
        r   = rnd();
        sel = (scn == 3) ? 3'h3 : 3'h1 << (scn % 3);
        @(negedge ref_clk_i);
        rst_i      = 1'b1;
        mm         = {r[7], sel, r[3:0]};
        pm         = {form, term, r[2:0]};
        wm         = {r[7:6], rx, r[4:0]};
        gn         = {r[7:3], ab, r[1:0]};
        cyc        = 16'h0002;
        eoc_mask_i = r[8];
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        #1 chk_stat({1'b0, zc_enable_o}, {1'b0, sel});
        @(negedge ref_clk_i);
        zc_pulse_i = 3'h7;
        for (int k = 0; k < 240; k++) begin
            @(negedge ref_clk_i);
            r              = rnd();
            m              = 24'h100000 | r[19:0];
            volt           = {3{24'h100000 | r[31:12]}};
            curr           = {3{ineg ? -m : m}};
            cshift         = {3{sneg ? -m : m}};
            sample_valid_i = 1'b1;
            zc_pulse_i     = (k == 100) ? (~sel & 3'h7) : 3'h0;
        end
        @(negedge ref_clk_i);
        sample_valid_i = 1'b0;
        // Odd scenarios end the period with no sample on the boundary
        if (scn % 2 == 1) @(negedge ref_clk_i);
        notes.push_back('{ela, elva, eoc_mask_i});
        zc_pulse_i = 3'h1 << (scn % 3);
        @(negedge ref_clk_i);
        zc_pulse_i = 3'h0;
        for (int k = 0; k < 20 && notes.size() != 0; k++) @(negedge ref_clk_i);
        if (notes.size() != 0) begin
            err_count++;
            hung = 1'b1;
        end
        for (int k = 0; k < 20 && eoc_flag_o !== 1'b0; k++) @(negedge ref_clk_i);
        chk_stat({3'h0, eoc_flag_o}, 4'h0);
        scn++;
    endtask

    initial begin
        rst_i = 1'b1;
        sample_valid_i = 1'b0;
        volt = '0;
        curr = '0;
        cshift = '0;
        zc_pulse_i = 3'h0;
        {mm, pm, wm, gn} = 32'h0;
        cyc = 16'h0000;
        eoc_mask_i = 1'b0;
        rs = 32'h00009289;
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        run(2'h0, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 2'h0);
        run(2'h0, 3'h7, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2, 2'h0);
        run(2'h0, 3'h7, 1'b0, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0);
        run(2'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        run(2'h0, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 2'h0);
        run(2'h1, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        run(2'h2, 3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 2'h0);
        run(2'h2, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        run(2'h3, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        run(2'h0, 3'h7, 1'b1, 1'b0, 1'b1, 1'b1, 2'h2, 2'h1);
        run(2'h0, 3'h7, 1'b1, 1'b1, 1'b0, 1'b0, 2'h1, 2'h1);
        run(2'h0, 3'h0, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 2'h0);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
